// [rtl/rcko_ahb_regs.sv]
// ahb-lite slave holding the reference clock control register
`include "rcko_params.svh"

module rcko_ahb_regs (
   // clock and reset
   input logic clk,
   input logic rst,
   // ahb-lite slave
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic [2:0] hsize,
   input logic [31:0] hwdata,
   input logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // control fields
   output rcko_pkg::rcko_ctrl_t ctrl
);
   localparam logic [31:0] CtrlAddr = `RCKO_CTRL_ADDR;

   logic take, hit;
   logic wr_pend_r, wr_pend_nxt;
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   // address phase decode; zero wait states so hready is always ours
   assign take = hsel & hready & htrans[1];
   assign hit = (haddr[31:2] == CtrlAddr[31:2]);

   // next values: write lands at end of data phase, read forwards it
   always_comb begin
      wr_pend_nxt = take & hwrite & hit & (hsize == `RCKO_HSIZE_WORD);
      ctrl_nxt = wr_pend_r ? hwdata[7:0] : ctrl_r;
      rdata_nxt = 32'h0;
      if (take & ~hwrite & hit) begin
         rdata_nxt = {24'h0, ctrl_nxt};
      end
   end

   // registers; reset restores defaults
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_pend_r <= 1'b0;
         ctrl_r <= `RCKO_CTRL_RST;
         rdata_r <= 32'h0;
      end else begin
         wr_pend_r <= wr_pend_nxt;
         ctrl_r <= ctrl_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_r;
   assign ctrl = rcko_pkg::rcko_ctrl_t'(ctrl_r);

   reset_default_a: assert property (@(posedge clk) $fell(rst) |->
      ctrl_r == `RCKO_CTRL_RST && ctrl_r[`RCKO_SLR_POS])
      else $error("control register not at default after reset");
   write_lands_a: assert property (@(posedge clk) disable iff (rst)
      wr_pend_r |=> ctrl_r == $past(hwdata[7:0]))
      else $error("register write not stored");

endmodule : rcko_ahb_regs

// [rtl/rcko_divider.sv]
// period counter and duty shaper of the reference clock
module rcko_divider (
   // clock and reset
   input logic clk,
   input logic rst,
   // control
   input logic enable,
   input logic sleep,
   input logic [2:0] div_sel,
   input logic [1:0] duty_sel,
   // shaped level, valid for the current count
   output logic wave
);
   logic [7:0] cnt_r, cnt_nxt;
   logic [2:0] div_r, div_nxt;
   logic [1:0] duty_r, duty_nxt;
   logic run_r, run_nxt;
   logic wrap;

   // last count of a period: 2*n - 1 half periods of the source
   function automatic logic [7:0] rcko_last(input logic [2:0] d);
      logic [8:0] p;
      p = 9'h002 << d;
      return 8'(p - 9'h001);
   endfunction : rcko_last

   // counts of high level for each duty code
   function automatic logic [8:0] rcko_high(input logic [2:0] d, input logic [1:0] c);
      logic [8:0] n;
      n = 9'h001 << d;
      case (c)
         2'h0: return 9'h000;
         2'h1: return (d == 3'h0) ? 9'h001 : (n >> 1);
         2'h2: return n;
         default: return (d == 3'h0) ? 9'h001 : (n + (n >> 1));
      endcase
   endfunction : rcko_high

   assign wrap = (cnt_r == rcko_last(div_r));

   // counter runs on clk alone; settings load at a period edge or while disabled
   always_comb begin
      cnt_nxt = cnt_r;
      div_nxt = div_r;
      duty_nxt = duty_r;
      run_nxt = run_r;
      if (!enable) begin
         cnt_nxt = 8'h00;
         div_nxt = div_sel;
         duty_nxt = duty_sel;
         run_nxt = 1'b0;
      end else if (!sleep) begin
         run_nxt = 1'b1;
         cnt_nxt = wrap ? 8'h00 : 8'(cnt_r + 8'h01);
         if (wrap) begin
            div_nxt = div_sel;
            duty_nxt = duty_sel;
         end
      end
   end

   // registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 8'h00;
         div_r <= 3'h0;
         duty_r <= 2'h0;
         run_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         div_r <= div_nxt;
         duty_r <= duty_nxt;
         run_r <= run_nxt;
      end
   end

   // div 1 and the div 2 quarter duties use both source edges, one clk cycle each
   assign wave = run_r & ({1'b0, cnt_r} < rcko_high(div_r, duty_r));

   off_cleared_a: assert property (@(posedge clk) disable iff (rst)
      !enable |=> cnt_r == 8'h00 && !wave)
      else $error("divider not cleared while disabled");
   count_step_a: assert property (@(posedge clk) disable iff (rst)
      enable && !sleep && !wrap |=> cnt_r == 8'($past(cnt_r) + 8'h01))
      else $error("divider did not advance");
   sleep_freeze_a: assert property (@(posedge clk) disable iff (rst)
      enable && sleep |=> $stable(cnt_r) && $stable(wave))
      else $error("divider moved in sleep");
   zero_duty_a: assert property (@(posedge clk) disable iff (rst)
      duty_r == 2'h0 |-> !wave)
      else $error("zero duty produced a high level");
   base_toggle_a: assert property (@(posedge clk) disable iff (rst)
      run_r && div_r == 3'h0 && duty_r != 2'h0 |-> wave == (cnt_r == 8'h00))
      else $error("base clock does not follow source");
   half_quarter_a: assert property (@(posedge clk) disable iff (rst)
      run_r && div_r == 3'h1 && duty_r == 2'h1 |-> wave == (cnt_r == 8'h00))
      else $error("div2 quarter duty wrong");
   div128_wrap_a: assert property (@(posedge clk) disable iff (rst)
      enable && !sleep && div_r == 3'h7 && cnt_r == 8'hff |=> cnt_r == 8'h00)
      else $error("divide by 128 period wrong");

endmodule : rcko_divider

// [rtl/rcko_params.svh]
// offsets, field positions, reset values and counts of the reference clock output
`ifndef RCKO_PARAMS_SVH
`define RCKO_PARAMS_SVH

// ***************************************************************
// register map
// ***************************************************************
`define RCKO_CTRL_ADDR 32'h0000_0000
`define RCKO_CTRL_RST 8'h30
`define RCKO_HSIZE_WORD 3'h2

// ***************************************************************
// ref_clock_control field positions
// ***************************************************************
`define RCKO_EN_POS 7
`define RCKO_OE_POS 6
`define RCKO_SLR_POS 5
`define RCKO_DUTY_LSB 3
`define RCKO_DIV_LSB 0

// ***************************************************************
// timing: one clk cycle is one half period of the source clock
// ***************************************************************
`define RCKO_QTR_LAST 2'h3

`endif

// [rtl/rcko_pkg.sv]
// types shared by the reference clock output design
package rcko_pkg;

   // ***************************************************************
   // control register layout, bit 7 down to bit 0
   // ***************************************************************
   typedef struct packed {
      logic ref_clock_enable;
      logic ref_output_enable;
      logic ref_slew_limit;
      logic [1:0] ref_duty_select;
      logic [2:0] ref_divider_select;
   } rcko_ctrl_t;

   // oscillator mode from the configuration word
   typedef enum logic [2:0] {
      low_power_crystal_mode = 3'h0,
      crystal_mode = 3'h1,
      high_speed_crystal_mode = 3'h2,
      external_clock_mode = 3'h3,
      internal_osc_mode = 3'h4
   } rcko_osc_mode_t;

   // who owns the shared pin
   typedef enum logic [1:0] {
      src_none = 2'h0,
      src_ref = 2'h1,
      src_quarter = 2'h2,
      src_osc_in = 2'h3
   } rcko_pin_src_t;

   // shared pin: level, active-low enable, slew limiting
   typedef struct packed {
      logic level;
      logic drive_n;
      logic slew_limit;
   } rcko_pin_t;

endpackage : rcko_pkg

// [rtl/rcko_top.sv]
// reference clock output: ahb-lite register, divider and pin ownership
//
// Function
// - output derived only from system clock
// - module runs only while enable set
// - pin driven only when output enable set; quarter clock out drives it regardless of output enable
// - three-bit field selects eight divide ratios
// - two-bit field selects duty cycle
// - undivided keeps source duty; zero duty constant
// - div2 quarter duties use both source edges
// - slew limiting follows its control bit
// - reset disables module, restores register defaults
// - crystal modes keep pin as oscillator input
// - quarter clock out overrides reference clock
// - module frozen during sleep
// - output holds last level in sleep
// - codes give divide 1 up to 128
// - duty codes 0, 25, 50, 75 percent
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`include "rcko_params.svh"

module rcko_top (
   // clock and reset
   input logic clk,
   input logic rst,
   // ahb-lite slave
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic [2:0] hsize,
   input logic [31:0] hwdata,
   input logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // device context
   input logic sleep,
   input rcko_pkg::rcko_osc_mode_t osc_mode,
   input logic sysclk_out_config,
   // shared output pin
   output rcko_pkg::rcko_pin_t ref_clock_pin
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   rcko_pkg::rcko_ctrl_t ctrl;
   rcko_pkg::rcko_pin_t pin_r, pin_nxt;
   rcko_pkg::rcko_pin_src_t src;
   logic wave;
   logic [1:0] qtr_cnt_r, qtr_cnt_nxt;
   logic qtr_lvl_r, qtr_lvl_nxt;
   logic xtal;

   // ***************************************************************
   // register file
   // ***************************************************************
   rcko_ahb_regs rcko_ahb_regs_i (
      .clk(clk),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .ctrl(ctrl)
   );

   // ***************************************************************
   // divider
   // ***************************************************************
   rcko_divider rcko_divider_i (
      .clk(clk),
      .rst(rst),
      .enable(ctrl.ref_clock_enable),
      .sleep(sleep),
      .div_sel(ctrl.ref_divider_select),
      .duty_sel(ctrl.ref_duty_select),
      .wave(wave)
   );

   // ***************************************************************
   // quarter clock: clk is one source half period, so fosc/4 is clk/8
   // ***************************************************************

   // free running outside sleep; the sleep input freezes count and level
   always_comb begin
      qtr_cnt_nxt = qtr_cnt_r;
      qtr_lvl_nxt = qtr_lvl_r;
      if (!sleep) begin
         qtr_cnt_nxt = 2'(qtr_cnt_r + 2'h1);
         if (qtr_cnt_r == `RCKO_QTR_LAST) begin
            qtr_lvl_nxt = ~qtr_lvl_r;
         end
      end
   end

   // quarter clock registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         qtr_cnt_r <= 2'h0;
         qtr_lvl_r <= 1'b0;
      end else begin
         qtr_cnt_r <= qtr_cnt_nxt;
         qtr_lvl_r <= qtr_lvl_nxt;
      end
   end

   // ***************************************************************
   // pin ownership
   // ***************************************************************

   // crystal modes need the pin as oscillator input
   assign xtal = (osc_mode == rcko_pkg::low_power_crystal_mode) ||
                 (osc_mode == rcko_pkg::crystal_mode) ||
                 (osc_mode == rcko_pkg::high_speed_crystal_mode);

   // priority: crystal, then quarter clock, then reference clock
   always_comb begin
      if (xtal) begin
         src = rcko_pkg::src_osc_in;
      end else if (sysclk_out_config) begin
         src = rcko_pkg::src_quarter;
      end else if (ctrl.ref_clock_enable && ctrl.ref_output_enable) begin
         src = rcko_pkg::src_ref;
      end else begin
         src = rcko_pkg::src_none;
      end
   end

   // pin next value; everything holds while asleep
   always_comb begin
      pin_nxt = pin_r;
      if (!sleep) begin
         pin_nxt.slew_limit = ctrl.ref_slew_limit;
         case (src)
            rcko_pkg::src_quarter: begin
               pin_nxt.level = qtr_lvl_r;
               pin_nxt.drive_n = 1'b0;
            end
            rcko_pkg::src_ref: begin
               pin_nxt.level = wave;
               pin_nxt.drive_n = 1'b0;
            end
            default: begin
               pin_nxt.level = 1'b0;
               pin_nxt.drive_n = 1'b1;
            end
         endcase
      end
   end

   // pin register: outputs leave straight from here
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_r <= '{level: 1'b0, drive_n: 1'b1, slew_limit: 1'b1};
      end else begin
         pin_r <= pin_nxt;
      end
   end

   assign ref_clock_pin = pin_r;

   // ***************************************************************
   // checks
   // ***************************************************************
   crystal_pin_free_a: assert property (@(posedge clk) disable iff (rst)
      !sleep && xtal |=> pin_r.drive_n)
      else $error("pin driven in crystal mode");

   quarter_drive_a: assert property (@(posedge clk) disable iff (rst)
      !sleep && !xtal && sysclk_out_config |=> !pin_r.drive_n && pin_r.level == $past(qtr_lvl_r))
      else $error("quarter clock not on pin");

   output_gate_a: assert property (@(posedge clk) disable iff (rst)
      !sleep && !sysclk_out_config && !ctrl.ref_output_enable |=> pin_r.drive_n)
      else $error("pin driven without output enable");

   disabled_gate_a: assert property (@(posedge clk) disable iff (rst)
      !sleep && !sysclk_out_config && !ctrl.ref_clock_enable |=> pin_r.drive_n)
      else $error("pin driven while module disabled");

   ref_level_a: assert property (@(posedge clk) disable iff (rst)
      !sleep && src == rcko_pkg::src_ref |=> pin_r.level == $past(wave) && !pin_r.drive_n)
      else $error("reference clock not on pin");

   sleep_hold_a: assert property (@(posedge clk) disable iff (rst)
      sleep |=> $stable(pin_r))
      else $error("pin changed during sleep");

   slew_follow_a: assert property (@(posedge clk) disable iff (rst)
      !sleep |=> pin_r.slew_limit == $past(ctrl.ref_slew_limit))
      else $error("slew limit does not follow control");

   quarter_period_a: assert property (@(posedge clk) disable iff (rst)
      !sleep [*5] |-> qtr_lvl_r != $past(qtr_lvl_r, 4))
      else $error("quarter clock period wrong");

   reset_pin_a: assert property (@(posedge clk) $fell(rst) |->
      pin_r.drive_n && !pin_r.level)
      else $error("pin driven right after reset");

endmodule : rcko_top

// [verification/rcko_ext_dev.sv]
// external device sampling the reference pin on clk: measures period and high time
module rcko_ext_dev (
   // clock
   input logic clk,
   // shared pin as seen by the device
   input rcko_pkg::rcko_pin_t pin,
   // measured waveform, in clk cycles
   output logic [8:0] period,
   output logic [8:0] high_len,
   output logic [15:0] rises
);
   timeunit 1ns;
   timeprecision 1ns;

   logic lvl;
   logic prev;
   logic [8:0] cnt;
   logic [8:0] hi;

   // undriven pin reads low, as through a pull-down
   assign lvl = !pin.drive_n && pin.level;

   initial begin
      prev = 1'b0;
      cnt = 9'h0;
      hi = 9'h0;
      period = 9'h0;
      high_len = 9'h0;
      rises = 16'h0;
   end

   // a rising edge closes one period; first result after enable is junk
   always @(posedge clk) begin
      prev <= lvl;
      if (lvl && !prev) begin
         period <= cnt;
         high_len <= hi;
         cnt <= 9'h1;
         hi <= 9'h1;
         rises <= rises + 16'h1;
      end else begin
         cnt <= cnt + 9'h1;
         hi <= hi + {8'h0, lvl};
      end
   end
endmodule : rcko_ext_dev

// [verification/reference_clock_output_tb.sv]
// self-checking testbench of the reference clock output
module reference_clock_output_tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk;
   logic rst;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic sleep;
   rcko_pkg::rcko_osc_mode_t osc_mode;
   logic sysclk_out_config;
   rcko_pkg::rcko_pin_t pin;
   logic [8:0] period;
   logic [8:0] high_len;
   logic [15:0] rises;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   logic [31:0] rd;

   rcko_top rcko_top_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleep(sleep),
      .osc_mode(osc_mode), .sysclk_out_config(sysclk_out_config), .ref_clock_pin(pin));

   rcko_ext_dev rcko_ext_dev_i (.clk(clk), .pin(pin), .period(period),
      .high_len(high_len), .rises(rises));

   // ***************************************************************
   // clock and hang guard
   // ***************************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // whole run is well under 20k cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 50000) begin
         n_errors = n_errors + 1;
         complete_run();
      end
   end

   // ***************************************************************
   // helpers
   // ***************************************************************
   task complete_run;
      $display("mismatches %0d, comparisons %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // address phase held until hready, then data phase until hready
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= sz;
      @(posedge clk);
      while (!hreadyout) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (!hreadyout) @(posedge clk);
      rd = hrdata;
   endtask : ahb

   function automatic logic [31:0] cw(logic en, logic oe, logic slr, logic [1:0] dt,
                                      logic [2:0] dv);
      cw = {24'h0, en, oe, slr, dt, dv};
   endfunction : cw

   task pin_chk(input logic drv_n);
      chk({31'h0, pin.drive_n}, {31'h0, drv_n});
   endtask : pin_chk

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin : main
      logic [8:0] exp_hi;
      logic lv;
      logic [15:0] rs;
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      sleep = 1'b0;
      osc_mode = rcko_pkg::internal_osc_mode;
      sysclk_out_config = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // defaults after reset
      pin_chk(1'b1);
      ahb(1'b0, 32'h0, 32'h0, 3'h2);
      chk(rd, 32'h0000_0030);
      // unmapped place and narrow write change nothing
      ahb(1'b1, 32'h0000_0004, 32'h0000_00ff, 3'h2);
      ahb(1'b1, 32'h0, 32'h0000_00ff, 3'h0);
      ahb(1'b0, 32'h0000_0004, 32'h0, 3'h2);
      chk(rd, 32'h0);
      ahb(1'b0, 32'h0, 32'h0, 3'h2);
      chk(rd, 32'h0000_0030);
      // every ratio with each nonzero duty; fields set before enabling
      for (int dv = 0; dv < 8; dv++) begin
         for (int dt = 1; dt < 4; dt++) begin
            ahb(1'b1, 32'h0, cw(1'b0, 1'b0, dt[0], dt[1:0], dv[2:0]), 3'h2);
            ahb(1'b1, 32'h0, cw(1'b1, 1'b1, dt[0], dt[1:0], dv[2:0]), 3'h2);
            repeat (3 * (2 << dv) + 4) @(posedge clk);
            exp_hi = 9'((dt * (1 << dv)) / 2);
            if (exp_hi == 9'h0) begin
               exp_hi = 9'h1;
            end
            chk({23'h0, period}, 32'(2 << dv));
            chk({23'h0, high_len}, {23'h0, exp_hi});
            pin_chk(1'b0);
            chk({31'h0, pin.slew_limit}, {31'h0, dt[0]});
            ahb(1'b0, 32'h0, 32'h0, 3'h2);
            chk(rd, cw(1'b1, 1'b1, dt[0], dt[1:0], dv[2:0]));
         end
      end
      // zero duty keeps the pin low
      ahb(1'b1, 32'h0, cw(1'b1, 1'b1, 1'b0, 2'h0, 3'h0), 3'h2);
      // old period may still run up to 256 cycles; its rise is already past
      repeat (4) @(posedge clk);
      rs = rises;
      repeat (300) @(posedge clk);
      chk({16'h0, rises}, {16'h0, rs});
      // output enable or module enable missing: pin not driven
      ahb(1'b1, 32'h0, cw(1'b1, 1'b0, 1'b0, 2'h2, 3'h1), 3'h2);
      repeat (4) @(posedge clk);
      pin_chk(1'b1);
      ahb(1'b1, 32'h0, cw(1'b0, 1'b1, 1'b0, 2'h2, 3'h1), 3'h2);
      repeat (4) @(posedge clk);
      pin_chk(1'b1);
      // sleep freezes the output at its level, waking resumes toggling
      // period 16 here, so the quarter clock check below sees a change
      ahb(1'b1, 32'h0, cw(1'b1, 1'b1, 1'b0, 2'h2, 3'h3), 3'h2);
      repeat (13) @(posedge clk);
      sleep <= 1'b1;
      repeat (2) @(posedge clk);
      lv = pin.level;
      rs = rises;
      repeat (40) @(posedge clk);
      chk({31'h0, pin.level}, {31'h0, lv});
      chk({16'h0, rises}, {16'h0, rs});
      sleep <= 1'b0;
      repeat (40) @(posedge clk);
      chk({31'h0, rises != rs}, 32'h1);
      // quarter clock out takes the pin, crystal modes take it from both
      sysclk_out_config <= 1'b1;
      repeat (40) @(posedge clk);
      chk({23'h0, period}, 32'h8);
      chk({23'h0, high_len}, 32'h4);
      for (int m = 0; m < 3; m++) begin
         osc_mode <= rcko_pkg::rcko_osc_mode_t'(m);
         repeat (3) @(posedge clk);
         pin_chk(1'b1);
      end
      // reset in mid-run restores defaults and stops the module
      osc_mode <= rcko_pkg::internal_osc_mode;
      sysclk_out_config <= 1'b0;
      repeat (20) @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      pin_chk(1'b1);
      rst <= 1'b0;
      @(posedge clk);
      ahb(1'b0, 32'h0, 32'h0, 3'h2);
      chk(rd, 32'h0000_0030);
      complete_run();
   end
endmodule : reference_clock_output_tb
